/* dv/csr_partner.sv */
// Pipeline model issuing exception entry and return events.
// Assumes the bench raises one request at a time.
`timescale 1ns/10ps
module csr_partner (
    input  wire logic        MCLK_IN,
    input  wire logic        GO_ENTRY_IN,
    input  wire logic        GO_RET_IN,
    input  wire logic [8:0]  NUM_IN,
    input  wire logic [3:0]  CODE_IN,
    output logic             ENTRY_OUT = 1'b0,
    output logic             RET_OUT   = 1'b0,
    output logic      [8:0]  NUM_OUT   = 9'h000,
    output logic      [3:0]  CODE_OUT  = 4'h0,
    output logic      [31:0] PSR_OUT   = 32'h0
);
    // Fields toggle outside events so the block cannot lean on stale values
    always @(posedge MCLK_IN) begin
        ENTRY_OUT <= GO_ENTRY_IN;
        RET_OUT   <= GO_RET_IN;
        NUM_OUT   <= GO_ENTRY_IN ? NUM_IN : ~NUM_OUT;
        CODE_OUT  <= GO_RET_IN ? CODE_IN : ~CODE_OUT;
        PSR_OUT   <= GO_RET_IN ? 32'h01000000 : ~PSR_OUT;
    end
endmodule : csr_partner

/* dv/csr_status_regs_props.sv */
// Port checker for the special-register block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/10ps
module csr_props (
    // Clock, reset and move port
    input wire logic        MCLK_IN,
    input wire logic        NRST_IN,
    input wire logic        SR_RD_IN,
    input wire logic [3:0]  SR_SEL_IN,
    input wire logic [31:0] SR_RDATA_OUT,
    // Exception events and candidate check
    input wire logic        EXC_ENTRY_IN,
    input wire logic        EXC_RET_IN,
    input wire logic [3:0]  EXC_RET_CODE_IN,
    input wire logic        PROC_STACK_OUT,
    input wire logic [8:0]  CAND_NUM_IN,
    input wire logic        CAND_BLOCKED_OUT
);
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!NRST_IN);
    property p_flags; SR_RD_IN && SR_SEL_IN == 4'h0 |=> SR_RDATA_OUT[26:0] == 27'h0; endproperty
    a_flags: assert property (p_flags) else $error("flag read low bits set");
    property p_excnum; SR_RD_IN && SR_SEL_IN == 4'h1 |=> SR_RDATA_OUT[31:9] == 23'h0; endproperty
    a_excnum: assert property (p_excnum) else $error("number read high bits set");
    property p_exec; SR_RD_IN && SR_SEL_IN == 4'h2 |=> SR_RDATA_OUT == 32'h0; endproperty
    a_exec: assert property (p_exec) else $error("state read not zero");
    property p_thr;
        SR_RD_IN && SR_SEL_IN == 4'h9 |=> (SR_RDATA_OUT & 32'hFFFFFF1F) == 32'h0;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold read bits set");
    property p_entry; EXC_ENTRY_IN |=> !PROC_STACK_OUT; endproperty
    a_entry: assert property (p_entry) else $error("handler on process stack");
    property p_ret; EXC_RET_IN && !EXC_ENTRY_IN && EXC_RET_CODE_IN == 4'hD |=> PROC_STACK_OUT;
    endproperty
    a_ret: assert property (p_ret) else $error("return kept main stack");
    property p_nmi; CAND_NUM_IN == 9'h002 |=> !CAND_BLOCKED_OUT; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi candidate blocked");
    property p_zero; CAND_NUM_IN == 9'h000 |=> CAND_BLOCKED_OUT; endproperty
    a_zero: assert property (p_zero) else $error("thread number accepted");
endmodule : csr_props
bind csr_status_regs csr_props csr_props_inst (.*);

/* dv/tb_core_status_mask_registers.sv */
// Self-checking bench for the special-register block.
// Assumes the partner model supplies exception events.
`timescale 1ns/10ps
module tb_core_status_mask_registers;
    logic clk = 0, nrst = 0, rd_s = 0, wr_s = 0, instruction_sync_barrier = 0, ge = 0, gr = 0, rv, ps, cb, tf, en, rt;
    logic [3:0] sel = 4'h0, pcode = 4'h0, rc, rreg;
    logic [8:0] cn = 9'h000, pnum = 9'h000, en_n;
    logic [7:0] cp = 8'h00;
    logic [25:0] m = 26'h0000101;  // Misc pipeline strobes; vector and state-value bits at 1
    logic rsv, hd, pv, ca;         // Resume, handler, privilege and block-active levels
    logic [3:0] cc;                // Current block condition
    logic [4:0] fo;                // Registered flags
    logic [31:0] wd = 32'h0, rdat, rcode, spsr, d, q[$];
    int mismatches = 0, checked = 0, cyc = 0, seed = 20962;
    initial forever #5 clk = ~clk;
    csr_partner csr_partner_inst (.MCLK_IN(clk), .GO_ENTRY_IN(ge), .GO_RET_IN(gr), .NUM_IN(pnum),
        .CODE_IN(pcode), .ENTRY_OUT(en), .RET_OUT(rt), .NUM_OUT(en_n), .CODE_OUT(rc), .PSR_OUT(spsr));
    csr_status_regs csr_status_regs_inst (.MCLK_IN(clk), .NRST_IN(nrst), .SR_RD_IN(rd_s),
        .SR_WR_IN(wr_s), .SR_SEL_IN(sel), .SR_WDATA_IN(wd), .SR_RDATA_OUT(rdat), .SR_RVALID_OUT(rv),
        .FLAGS_WE_IN(m[1]), .FLAGS_IN(m[6:2]), .FLAGS_OUT(fo), .EXC_ENTRY_IN(en),
        .EXC_NUM_IN(en_n), .EXC_VEC_BIT0_IN(m[0]), .EXC_RET_CODE_OUT(rcode), .EXC_RET_IN(rt),
        .EXC_RET_CODE_IN(rc), .STACKED_PSR_IN(spsr), .TBIT_LOAD_IN(m[7]), .TBIT_VAL_IN(m[8]),
        .EXEC_IN(m[9]), .TBIT_FAULT_OUT(tf), .MULTI_SUSPEND_IN(m[10]),
        .MULTI_NEXT_REG_IN(m[14:11]), .MULTI_DONE_IN(m[15]), .RESUME_VALID_OUT(rsv),
        .RESUME_REG_OUT(rreg), .COND_START_IN(m[16]), .COND_FIELD_IN(m[24:17]),
        .COND_ADVANCE_IN(m[25]), .COND_ACTIVE_OUT(ca), .COND_CODE_OUT(cc), .ISB_IN(instruction_sync_barrier),
        .PROC_STACK_OUT(ps), .HANDLER_OUT(hd), .PRIV_OUT(pv), .CAND_NUM_IN(cn),
        .CAND_PRI_IN(cp), .CAND_BLOCKED_OUT(cb));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Move-port cycles: request held one edge, read answer noted in the queue
    task automatic do_wr(input logic [3:0] s, input logic [31:0] v);
        @(posedge clk) #1 wr_s = 1;
        sel = s;
        wd = v;
        @(posedge clk) #1 wr_s = 0;
    endtask : do_wr
    task automatic do_rd(input logic [3:0] s, input logic [31:0] e);
        @(posedge clk) #1 rd_s = 1;
        sel = s;
        q.push_back(e);
        @(posedge clk) #1 rd_s = 0;
    endtask : do_rd
    task automatic cand(input logic [8:0] n, input logic [7:0] p, input logic e);
        @(posedge clk) #1 cn = n;
        cp = p;
        @(posedge clk) #1 chk({31'h0, cb}, {31'h0, e});
    endtask : cand
    // Read answers compared oldest first; cycle ceiling cuts a hang short
    always @(posedge clk) begin
        if (rv === 1'b1) chk(rdat, q.pop_front());
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1;
        for (int s = 0; s < 16; s++) do_rd(s[3:0], 32'h0);
        d = $random(seed);
        do_wr(4'h0, d);
        do_rd(4'h0, d & 32'hF8000000);
        do_rd(4'h3, d & 32'hF8000000);
        chk({27'h0, fo}, {27'h0, d[31:27]});
        // ALU update of the flags, then read back through the move port
        m[6:1] = 6'h2B;
        @(posedge clk) #1 m[1] = 0;
        do_rd(4'h0, 32'hA8000000);
        do_wr(4'h2, 32'hFFFFFFFF);
        do_rd(4'h2, 32'h0);
        do_wr(4'h9, 32'hFFFFFFFF);
        do_rd(4'h9, 32'hE0);
        do_wr(4'h9, 32'h40);
        cand(9'h010, 8'h40, 1);
        cand(9'h0FF, 8'h3F, 0);
        cand(9'h100, 8'h00, 1);
        cand(9'h007, 8'h00, 1);
        do_wr(4'h9, 32'h0);
        do_wr(4'h7, 32'hFFFFFFFF);
        do_rd(4'h7, 32'h1);
        cand(9'h00B, 8'h00, 1);
        cand(9'h003, 8'h00, 0);
        do_wr(4'h7, 32'h0);
        do_wr(4'hA, 32'h2);
        chk({31'h0, ps}, 32'h0);
        @(posedge clk) #1 instruction_sync_barrier = 1;
        @(posedge clk) #1 instruction_sync_barrier = 0;
        @(posedge clk) #1 chk({31'h0, ps}, 32'h1);
        do_wr(4'h8, 32'h1);
        cand(9'h010, 8'h00, 1);
        cand(9'h002, 8'h00, 0);
        pnum = 9'h010;
        @(posedge clk) #1 ge = 1;
        @(posedge clk) #1 ge = 0;
        repeat (3) @(posedge clk);
        #1 chk(rcode, 32'hFFFFFFFD);
        chk({30'h0, hd, ps}, 32'h2);
        do_rd(4'h1, 32'h10);
        do_rd(4'hA, 32'h0);
        pcode = 4'hD;
        @(posedge clk) #1 gr = 1;
        @(posedge clk) #1 gr = 0;
        repeat (3) @(posedge clk);
        #1 chk({30'h0, hd, ps}, 32'h1);
        do_rd(4'h8, 32'h0);
        do_rd(4'hA, 32'h2);
        // Branch loads a clear state bit, then an issue attempt must fault
        m[8:7] = 2'b01;
        @(posedge clk) #1 m[9:7] = 3'b100;
        @(posedge clk) #1 m[9] = 0;
        chk({31'h0, tf}, 32'h1);
        m[14:11] = 4'h5;
        @(posedge clk) #1 m[10] = 1;
        @(posedge clk) #1 m[10] = 0;
        repeat (2) @(posedge clk);
        #1 chk({27'h0, rsv, rreg}, 32'h15);
        // Four-instruction block: start, then advance on every edge
        m[24:16] = 9'h143;
        @(posedge clk) #1 m[25:16] = 10'h342;
        repeat (3) @(posedge clk);
        #1 chk({27'h0, ca, cc}, 32'h1A);
        @(posedge clk) #1 m[25] = 0;
        @(posedge clk) #1 chk({27'h0, ca, cc}, 32'h0);
        // Drop to unprivileged thread; mask writes must then be ignored
        do_wr(4'hA, 32'h3);
        do_wr(4'h7, 32'h1);
        chk({31'h0, pv}, 32'h0);
        do_rd(4'hA, 32'h3);
        cand(9'h00B, 8'h00, 0);
        give_verdict();
    end
endmodule : tb_core_status_mask_registers

/* verilog/csr_pkg.sv */
// Shared constants and types for the core special-register block.
// Assumes the pipeline and exception logic run on the same core clock.
package csr_pkg;

    // Special-register selector carried by the move instructions
    typedef enum logic [3:0] {
        SEL_FLAGS      = 4'h0,  // Condition flags only
        SEL_EXCNUM     = 4'h1,  // Active exception number only
        SEL_EXEC       = 4'h2,  // Execution state only
        SEL_ALL        = 4'h3,  // Combined status word
        SEL_EXC_EXEC   = 4'h4,  // Exception number and execution state
        SEL_FLAGS_EXC  = 4'h5,  // Flags and exception number
        SEL_FLAGS_EXEC = 4'h6,  // Flags and execution state
        SEL_PRIDIS     = 4'h7,  // Configurable-priority disable
        SEL_FLTDIS     = 4'h8,  // All-but-NMI disable
        SEL_THRESH     = 4'h9,  // Priority threshold
        SEL_CTRL       = 4'hA   // Thread stack/privilege control
    } csr_sel_e;

    // Condition flags, most significant first
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
        logic q;
    } csr_flags_s;

    // Field positions
    localparam int unsigned FLAGS_LSB      = 27;
    localparam int unsigned EXCNUM_W       = 9;
    localparam int unsigned T_BIT          = 24;
    localparam int unsigned CIT_HI_LSB     = 25;
    localparam int unsigned CIT_LO_LSB     = 10;
    localparam int unsigned MASK_BIT       = 0;
    localparam int unsigned THRESH_W       = 8;
    localparam int unsigned CTRL_STACK_POINTER_SELECT_BIT = 1;
    localparam int unsigned CTRL_THREAD_UNPRIVILEGED_BIT_BIT = 0;
    localparam int unsigned RET_PSP_BIT    = 2;
    localparam int unsigned RET_THREAD_BIT = 3;

    // Reset values
    localparam logic [31:0] PSR_RST  = 32'h01000000;
    localparam logic [31:0] MASK_RST = 32'h00000000;

    // Exception type numbers
    localparam logic [8:0] EXC_THREAD  = 9'h000;
    localparam logic [8:0] EXC_NMI     = 9'h002;
    localparam logic [8:0] EXC_FAULT   = 9'h003;
    localparam logic [8:0] EXC_MEMPROT = 9'h004;
    localparam logic [8:0] EXC_USAGE   = 9'h006;
    localparam logic [8:0] EXC_SVC     = 9'h00B;
    localparam logic [8:0] EXC_PENDABLE_SERVICE_REQUEST  = 9'h00E;
    localparam logic [8:0] EXC_TICK    = 9'h00F;
    localparam logic [8:0] EXC_EXT0    = 9'h010;

    // Implemented priority bits (upper bits of the 8-bit field)
    localparam int unsigned PRI_BITS = 3;
    localparam logic [7:0]  PRI_MASK = 8'hE0;

    // Exception return codes produced on entry
    localparam logic [31:0] RET_HANDLER     = 32'hFFFFFFF1;
    localparam logic [31:0] RET_THREAD_MAIN = 32'hFFFFFFF9;
    localparam logic [31:0] RET_THREAD_PROC = 32'hFFFFFFFD;

endpackage : csr_pkg

/* verilog/csr_status_regs.sv */
// Core special registers: flags, exception number, execution state, masks, control.
// Assumes all requests come from same-clock pipeline logic, one event per input.
// Notes on behaviour
// - Flags N,Z,C,V,Q at bits 31..27
// - Low nine bits report active exception
// - Fixed exception numbering, reserved codes rejected
// - NUM_IRQ parameter; line n-1 is n+15
// - Execution state field at 26:25, 15:10
// - Direct reads zero, direct writes ignored
// - Suspended multiple-transfer keeps next register
// - Resume state keeps other field bits zero
// - Conditional block of up to four instructions
// - State bit cleared only by listed events
// - Executing with state bit zero faults
// - Priority disable blocks configurable exceptions
// - Fault disable blocks all but NMI
// - Fault disable cleared leaving non-NMI handler
// - Nonzero threshold blocks equal or lower priority
// - Unimplemented threshold bits read zero
// - Stack select reads zero in handler
// - Bit 0 selects thread privilege
// - Entry/return update control from return code
// - Handler uses main stack; reset thread main
// - New stack applies after sync barrier
// - Exceptions serviced in handler mode, prioritised
// - Combined writes ignore number, execution bits
// - Status resets 0x01000000, others zero
`timescale 1ns/10ps
module csr_status_regs #(
    parameter int unsigned NUM_IRQ = 240      // External interrupt lines, 1 to 240
) (
    // Clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 NRST_IN,
    // Special-register move port
    input  wire logic                 SR_RD_IN,
    input  wire logic                 SR_WR_IN,
    input  wire logic [3:0]           SR_SEL_IN,
    input  wire logic [31:0]          SR_WDATA_IN,
    output logic      [31:0]          SR_RDATA_OUT,
    output logic                      SR_RVALID_OUT,
    // Execution unit flag update
    input  wire logic                 FLAGS_WE_IN,
    input  wire csr_pkg::csr_flags_s  FLAGS_IN,
    output csr_pkg::csr_flags_s       FLAGS_OUT,
    // Exception entry
    input  wire logic                 EXC_ENTRY_IN,
    input  wire logic [8:0]           EXC_NUM_IN,
    input  wire logic                 EXC_VEC_BIT0_IN,
    output logic      [31:0]          EXC_RET_CODE_OUT,
    // Exception return
    input  wire logic                 EXC_RET_IN,
    input  wire logic [3:0]           EXC_RET_CODE_IN,
    input  wire logic [31:0]          STACKED_PSR_IN,
    // Instruction-set state
    input  wire logic                 TBIT_LOAD_IN,
    input  wire logic                 TBIT_VAL_IN,
    input  wire logic                 EXEC_IN,
    output logic                      TBIT_FAULT_OUT,
    // Interruptible multiple transfer
    input  wire logic                 MULTI_SUSPEND_IN,
    input  wire logic [3:0]           MULTI_NEXT_REG_IN,
    input  wire logic                 MULTI_DONE_IN,
    output logic                      RESUME_VALID_OUT,
    output logic      [3:0]           RESUME_REG_OUT,
    // Conditional block
    input  wire logic                 COND_START_IN,
    input  wire logic [7:0]           COND_FIELD_IN,
    input  wire logic                 COND_ADVANCE_IN,
    output logic                      COND_ACTIVE_OUT,
    output logic      [3:0]           COND_CODE_OUT,
    // Barrier and mode state
    input  wire logic                 ISB_IN,
    output logic                      PROC_STACK_OUT,
    output logic                      HANDLER_OUT,
    output logic                      PRIV_OUT,
    // Candidate exception check for the prioritiser
    input  wire logic [8:0]           CAND_NUM_IN,
    input  wire logic [7:0]           CAND_PRI_IN,
    output logic                      CAND_BLOCKED_OUT
);

    // Exception number is legal for this build
    function automatic logic exc_valid(input logic [8:0] num);
        logic ok;
        ok = 1'b0;
        if (num == csr_pkg::EXC_THREAD) begin
            ok = 1'b1;
        end else if (num >= csr_pkg::EXC_EXT0) begin
            ok = ({23'h000000, num} < (32'(NUM_IRQ) + 32'h00000010));
        end else begin
            ok = (num >= csr_pkg::EXC_NMI && num <= csr_pkg::EXC_USAGE)
               || num == csr_pkg::EXC_SVC
               || num == csr_pkg::EXC_PENDABLE_SERVICE_REQUEST
               || num == csr_pkg::EXC_TICK;
        end
        return ok;
    endfunction : exc_valid

    // Drop unimplemented low-order priority bits
    function automatic logic [7:0] pri_trim(input logic [7:0] pri);
        return pri & csr_pkg::PRI_MASK;
    endfunction : pri_trim

    // Architectural state
    csr_pkg::csr_flags_s flags_reg;       // Condition flags
    logic [8:0]          excnum_reg;      // Active exception number
    logic                tbit_reg;        // Instruction-set state bit
    logic [7:0]          cit_reg;         // Resume/conditional-block field
    logic                pridis_reg;      // Configurable-priority disable
    logic                fltdis_reg;      // All-but-NMI disable
    logic [7:0]          thresh_reg;      // Priority threshold
    logic                stack_pointer_select_reg;       // Thread stack select
    logic                thread_unprivileged_bit_reg;       // Thread unprivileged

    // Decoded request terms
    logic       handler;                  // Servicing an exception
    logic       privileged;               // Current code may touch masks
    logic       wr_priv;                  // Privileged move write
    logic       wr_flags;                 // Move write reaching flag bits
    csr_pkg::csr_sel_e sel;               // Typed selector

    assign sel        = csr_pkg::csr_sel_e'(SR_SEL_IN);
    assign handler    = (excnum_reg != csr_pkg::EXC_THREAD);
    assign privileged = handler | ~thread_unprivileged_bit_reg;
    assign wr_priv    = SR_WR_IN & privileged;
    assign wr_flags   = SR_WR_IN & (sel == csr_pkg::SEL_FLAGS
                                  || sel == csr_pkg::SEL_ALL
                                  || sel == csr_pkg::SEL_FLAGS_EXC
                                  || sel == csr_pkg::SEL_FLAGS_EXEC);

    // Condition flags: return restore wins over a move, a move over the ALU
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            flags_reg <= csr_pkg::csr_flags_s'(csr_pkg::PSR_RST[31:27]);
        end else if (EXC_RET_IN) begin
            flags_reg <= csr_pkg::csr_flags_s'(STACKED_PSR_IN[31:27]);
        end else if (wr_flags) begin
            // Only the five flag bits are taken; bits 26:0 are dropped
            flags_reg <= csr_pkg::csr_flags_s'(SR_WDATA_IN[31:27]);
        end else if (FLAGS_WE_IN) begin
            flags_reg <= FLAGS_IN;
        end
    end

    // Active exception number; moves never write it
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            excnum_reg <= csr_pkg::PSR_RST[8:0];
        end else if (EXC_ENTRY_IN && exc_valid(EXC_NUM_IN)) begin
            excnum_reg <= EXC_NUM_IN;
        end else if (EXC_RET_IN) begin
            // Returning to thread mode always lands on number zero
            if (EXC_RET_CODE_IN[csr_pkg::RET_THREAD_BIT]) begin
                excnum_reg <= csr_pkg::EXC_THREAD;
            end else begin
                excnum_reg <= STACKED_PSR_IN[8:0];
            end
        end
    end

    // Instruction-set state bit: only branches, return restore and vectors
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            tbit_reg <= csr_pkg::PSR_RST[csr_pkg::T_BIT];
        end else if (EXC_ENTRY_IN) begin
            tbit_reg <= EXC_VEC_BIT0_IN;
        end else if (EXC_RET_IN) begin
            tbit_reg <= STACKED_PSR_IN[csr_pkg::T_BIT];
        end else if (TBIT_LOAD_IN) begin
            tbit_reg <= TBIT_VAL_IN;
        end
    end

    // Faulting execution attempt while the state bit is clear
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            TBIT_FAULT_OUT <= 1'b0;
        end else begin
            TBIT_FAULT_OUT <= EXEC_IN & ~tbit_reg;
        end
    end

    // Resume/conditional-block field; bit order {15:10, 26:25}
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            cit_reg <= 8'h00;
        end else if (EXC_ENTRY_IN) begin
            // Handler starts clean; old value sits in the stacked word
            cit_reg <= 8'h00;
        end else if (EXC_RET_IN) begin
            cit_reg <= {STACKED_PSR_IN[15:10], STACKED_PSR_IN[26:25]};
        end else if (MULTI_SUSPEND_IN) begin
            // Next operand in 15:12, the rest of the field held at zero
            cit_reg <= {MULTI_NEXT_REG_IN, 4'h0};
        end else if (MULTI_DONE_IN) begin
            cit_reg <= 8'h00;
        end else if (COND_START_IN) begin
            cit_reg <= COND_FIELD_IN;
        end else if (COND_ADVANCE_IN && cit_reg[3:0] != 4'h0) begin
            // Mask shifts one place per instruction; at most four steps
            if (cit_reg[2:0] == 3'h0) begin
                cit_reg <= 8'h00;
            end else begin
                cit_reg <= {cit_reg[7:5], cit_reg[3:0], 1'b0};
            end
        end
    end

    // Resume and conditional-block outputs
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            RESUME_VALID_OUT <= 1'b0;
            RESUME_REG_OUT   <= 4'h0;
            COND_ACTIVE_OUT  <= 1'b0;
            COND_CODE_OUT    <= 4'h0;
        end else begin
            // Resume state is recognised by a zero mask and a nonzero register
            RESUME_VALID_OUT <= (cit_reg[3:0] == 4'h0) && (cit_reg[7:4] != 4'h0);
            RESUME_REG_OUT   <= cit_reg[7:4];
            COND_ACTIVE_OUT  <= (cit_reg[3:0] != 4'h0);
            COND_CODE_OUT    <= {cit_reg[7:5], cit_reg[4] & (cit_reg[3:0] != 4'h0)};
        end
    end

    // Configurable-priority disable
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            pridis_reg <= csr_pkg::MASK_RST[csr_pkg::MASK_BIT];
        end else if (wr_priv && sel == csr_pkg::SEL_PRIDIS) begin
            pridis_reg <= SR_WDATA_IN[csr_pkg::MASK_BIT];
        end
    end

    // All-but-NMI disable; auto-clears leaving a non-NMI handler
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            fltdis_reg <= csr_pkg::MASK_RST[csr_pkg::MASK_BIT];
        end else if (EXC_RET_IN && excnum_reg != csr_pkg::EXC_NMI) begin
            fltdis_reg <= 1'b0;
        end else if (wr_priv && sel == csr_pkg::SEL_FLTDIS) begin
            fltdis_reg <= SR_WDATA_IN[csr_pkg::MASK_BIT];
        end
    end

    // Priority threshold, only implemented bits kept
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            thresh_reg <= csr_pkg::MASK_RST[7:0];
        end else if (wr_priv && sel == csr_pkg::SEL_THRESH) begin
            thresh_reg <= pri_trim(SR_WDATA_IN[7:0]);
        end
    end

    // Thread control: privilege bit and stack select
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            thread_unprivileged_bit_reg <= csr_pkg::MASK_RST[csr_pkg::CTRL_THREAD_UNPRIVILEGED_BIT_BIT];
            stack_pointer_select_reg <= csr_pkg::MASK_RST[csr_pkg::CTRL_STACK_POINTER_SELECT_BIT];
        end else if (EXC_ENTRY_IN) begin
            stack_pointer_select_reg <= 1'b0;
        end else if (EXC_RET_IN) begin
            // Process stack only when the code returns to thread with it
            stack_pointer_select_reg <= EXC_RET_CODE_IN[csr_pkg::RET_THREAD_BIT]
                       & EXC_RET_CODE_IN[csr_pkg::RET_PSP_BIT];
        end else if (wr_priv && sel == csr_pkg::SEL_CTRL) begin
            thread_unprivileged_bit_reg <= SR_WDATA_IN[csr_pkg::CTRL_THREAD_UNPRIVILEGED_BIT_BIT];
            if (!handler) begin
                stack_pointer_select_reg <= SR_WDATA_IN[csr_pkg::CTRL_STACK_POINTER_SELECT_BIT];
            end
        end
    end

    // Active stack pointer: a move takes effect only at the barrier
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            PROC_STACK_OUT <= 1'b0;
        end else if (EXC_ENTRY_IN) begin
            PROC_STACK_OUT <= 1'b0;
        end else if (EXC_RET_IN) begin
            PROC_STACK_OUT <= EXC_RET_CODE_IN[csr_pkg::RET_THREAD_BIT]
                            & EXC_RET_CODE_IN[csr_pkg::RET_PSP_BIT];
        end else if (ISB_IN) begin
            PROC_STACK_OUT <= stack_pointer_select_reg & ~handler;
        end
    end

    // Return code handed to the entry logic, chosen from the interrupted context
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            EXC_RET_CODE_OUT <= csr_pkg::RET_THREAD_MAIN;
        end else if (EXC_ENTRY_IN) begin
            if (handler) begin
                EXC_RET_CODE_OUT <= csr_pkg::RET_HANDLER;
            end else if (stack_pointer_select_reg) begin
                EXC_RET_CODE_OUT <= csr_pkg::RET_THREAD_PROC;
            end else begin
                EXC_RET_CODE_OUT <= csr_pkg::RET_THREAD_MAIN;
            end
        end
    end

    // Mode, privilege and flag outputs
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            HANDLER_OUT <= 1'b0;
            PRIV_OUT    <= 1'b1;
            FLAGS_OUT   <= csr_pkg::csr_flags_s'(csr_pkg::PSR_RST[31:27]);
        end else begin
            HANDLER_OUT <= handler;
            PRIV_OUT    <= privileged;
            FLAGS_OUT   <= flags_reg;
        end
    end

    // Activation gate for one candidate; fixed-priority ones ignore threshold
    logic cand_cfg;                       // Candidate has configurable priority
    logic cand_block;                     // Candidate must not activate
    always_comb begin
        cand_cfg   = (CAND_NUM_IN >= csr_pkg::EXC_MEMPROT);
        cand_block = ~exc_valid(CAND_NUM_IN)
                   | (CAND_NUM_IN == csr_pkg::EXC_THREAD);
        if (fltdis_reg && CAND_NUM_IN != csr_pkg::EXC_NMI) begin
            cand_block = 1'b1;
        end
        if (pridis_reg && cand_cfg) begin
            cand_block = 1'b1;
        end
        // Larger value is lower priority, so >= threshold is masked
        if (thresh_reg != 8'h00 && cand_cfg
            && pri_trim(CAND_PRI_IN) >= thresh_reg) begin
            cand_block = 1'b1;
        end
    end

    // Registered gate result for the prioritiser
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            CAND_BLOCKED_OUT <= 1'b0;
        end else begin
            CAND_BLOCKED_OUT <= cand_block;
        end
    end

    // Read data: execution state reads zero, reserved bits zero
    logic [31:0] rdata_next;              // Word for the current read
    logic [31:0] flags_word;              // Flags in place
    logic [31:0] excnum_word;             // Exception number in place
    always_comb begin
        flags_word  = {flags_reg, 27'h0000000};
        excnum_word = {23'h000000, excnum_reg};
        rdata_next  = 32'h00000000;
        unique case (sel)
            csr_pkg::SEL_FLAGS:      rdata_next = flags_word;
            csr_pkg::SEL_EXCNUM:     rdata_next = privileged ? excnum_word : 32'h00000000;
            csr_pkg::SEL_EXEC:       rdata_next = 32'h00000000;
            csr_pkg::SEL_ALL:        rdata_next = privileged ? (flags_word | excnum_word)
                                                             : flags_word;
            csr_pkg::SEL_EXC_EXEC:   rdata_next = privileged ? excnum_word : 32'h00000000;
            csr_pkg::SEL_FLAGS_EXC:  rdata_next = privileged ? (flags_word | excnum_word)
                                                             : flags_word;
            csr_pkg::SEL_FLAGS_EXEC: rdata_next = flags_word;
            csr_pkg::SEL_PRIDIS:     rdata_next = {31'h00000000, pridis_reg & privileged};
            csr_pkg::SEL_FLTDIS:     rdata_next = {31'h00000000, fltdis_reg & privileged};
            csr_pkg::SEL_THRESH:     rdata_next = privileged ? {24'h000000, thresh_reg}
                                                             : 32'h00000000;
            csr_pkg::SEL_CTRL:       rdata_next = {30'h00000000, stack_pointer_select_reg & ~handler,
                                                   thread_unprivileged_bit_reg};
            default:                 rdata_next = 32'h00000000;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            SR_RDATA_OUT  <= 32'h00000000;
            SR_RVALID_OUT <= 1'b0;
        end else begin
            SR_RVALID_OUT <= SR_RD_IN;
            if (SR_RD_IN) begin
                SR_RDATA_OUT <= rdata_next;
            end
        end
    end

endmodule : csr_status_regs
